// ### design/ccmd_consts.svh
// Offsets, field positions, reset values and timing counts of the common command handler
`ifndef CCMD_CONSTS_SVH
`define CCMD_CONSTS_SVH
// Register byte offsets
`define REG_COMMAND      8'h00
`define REG_ARGUMENT     8'h04
`define REG_ANSWER       8'h08
`define REG_STATUS       8'h0c
`define REG_EVENT_ENABLE 8'h10
`define REG_SREQ_ENABLE  8'h14
`define REG_STATUS_BYTE  8'h18
`define REG_EVENT_STAT   8'h1c
`define REG_RELAY        8'h20
`define REG_SCAN         8'h24
`define REG_SELFTEST     8'h28
`define REG_EVENT_SET    8'h2c
// Command codes written to the command register
`define CMD_IDN 4'h1
`define CMD_RST 4'h2
`define CMD_TST 4'h3
`define CMD_OPC 4'h4
`define CMD_OPQ 4'h5
`define CMD_WAI 4'h6
`define CMD_CLS 4'h7
`define CMD_ESE 4'h8
`define CMD_ESQ 4'h9
`define CMD_ESR 4'ha
`define CMD_SRE 4'hb
`define CMD_SRQ 4'hc
`define CMD_STB 4'hd
`define CMD_TRG 4'he
`define CMD_RCL 4'hf
`define CMD_SAV 4'h0
// Self-test result codes, low byte of the +ccNN answers
`define TST_PASS     16'h0000
`define TST_FIRMWARE 16'h0001
`define TST_BUS      16'h0002
`define TST_NO_IRQ   16'h0010
`define TST_BUSY     16'h0011
// Field positions
`define EVT_OPC_BIT  0
`define STB_ESB_BIT  5
`define STB_MAV_BIT  4
`define STB_RQS_BIT  6
`define SCAN_EN_BIT  0
`define SCAN_BUS_BIT 1
// Identification word, value arbitrary
`define ID_WORD 32'h5a3c0001
// Busy hold time for the self-test
`define BUSY_HOLD_US 7000
`define CLK_MHZ      25
`define BUSY_HOLD_CYCLES (`BUSY_HOLD_US * `CLK_MHZ)
`define RELAY_RESET  16'h0000
`endif

// ### design/ccmd_pkg.sv
// Types of the common command handler
package ccmd_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_type;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_TEST = 4'b1000
  } state_type;
endpackage : ccmd_pkg

// ### design/common_command_status_handler.sv
// Common command interpreter with status reporting for a relay matrix
//
// Behaviour
// - Reset command opens every relay of the matrix.
// - Self-test result register reads zero when all checks pass.
// - Self-test reports firmware fault cc01 and bus fault cc02.
// - Self-test reports cc10 when the expected interrupt never arrives.
// - Self-test reports cc11 when busy was not held for 7 ms.
// - Operation-complete command sets request flag and event bit when idle.
// - Operation-complete query answers 1 only after pending work finishes.
// - Wait command ignores further commands until pending work finishes.
// - Clear-status clears event register, request flag and queues but output.
// - Event-enable command loads its mask argument.
// - Event-enable query returns the mask unchanged.
// - Event-status query returns the register and then clears it.
// - Service-request-enable command loads its mask for service requests.
// - Service-request-enable query returns that mask.
// - Status-byte query returns the present status byte.
// - Trigger advances scan only when scanning enabled and bus source set.
// - Save command stores the relay configuration.
// - Recall command restores the stored relay configuration.
// - Identification query returns an identification word.
// - Clear-status also empties the error queue.
`timescale 1ns/1ps
`include "ccmd_consts.svh"
module common_command_status_handler #(
  parameter int BUSY_HOLD = `BUSY_HOLD_CYCLES
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire ccmd_pkg::wb_req_type wb_req_in,
  output ccmd_pkg::wb_rsp_type    wb_rsp_out,
  input  wire logic               pending_in,
  input  wire logic               fw_fault_in,
  input  wire logic               bus_fault_in,
  input  wire logic               module_irq_in,
  input  wire logic               module_busy_in,
  input  wire logic               error_nonempty_in,
  output logic                    error_clear_out,
  output logic [15:0]             relay_out,
  output logic                    scan_step_out,
  output logic                    srq_out,
  output logic                    busy_out
);
  import ccmd_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_type   state;
  logic [3:0]  cmd;
  logic [7:0]  arg;
  logic [31:0] answer;
  logic        answer_valid;
  logic [7:0]  event_stat;
  logic [7:0]  event_enable;
  logic [7:0]  sreq_enable;
  logic        opc_request;
  logic [15:0] saved_relay;
  logic [1:0]  scan_ctl;
  logic [15:0] selftest;
  logic [23:0] busy_count;
  logic        irq_seen;
  logic        ack;
  logic [31:0] rdata;
  logic [7:0]  status_byte;
  logic [1:0]  pend_sync;
  logic [1:0]  irq_sync;
  logic [1:0]  busy_sync;
  logic [1:0]  fault_sync;
  logic [1:0]  fault2_sync;
  logic [1:0]  err_sync;
  logic        wr_cmd;
  logic        wr_access;
  logic        rd_access;
  logic        esr_read;
  logic        event_set_wr;
  logic        busy_seen;
  logic        test_done;
  logic        arg_wr;
  logic        scan_wr;
  logic        relay_wr;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Write strobe for one register offset; only byte lane 0 gates a write
  function automatic logic reg_write(input logic       access,
                                     input wb_req_type req,
                                     input logic [7:0] offset);
    reg_write = access && (req.adr == offset) && req.sel[0];
  endfunction : reg_write

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pend_sync   <= 2'h0;
      irq_sync    <= 2'h0;
      busy_sync   <= 2'h0;
      fault_sync  <= 2'h0;
      fault2_sync <= 2'h0;
      err_sync    <= 2'h0;
    end
    else
    begin
      pend_sync   <= {pend_sync[0], pending_in};
      irq_sync    <= {irq_sync[0], module_irq_in};
      busy_sync   <= {busy_sync[0], module_busy_in};
      fault_sync  <= {fault_sync[0], fw_fault_in};
      fault2_sync <= {fault2_sync[0], bus_fault_in};
      err_sync    <= {err_sync[0], error_nonempty_in};
    end
  end

  // ----------------------------------------
  // Wishbone slave decode
  // ----------------------------------------
  assign wr_access    = wb_req_in.cyc && wb_req_in.stb && !ack && wb_req_in.we;
  assign rd_access    = wb_req_in.cyc && wb_req_in.stb && !ack && !wb_req_in.we;
  assign wr_cmd       = reg_write(wr_access, wb_req_in, `REG_COMMAND);
  assign esr_read     = rd_access && (wb_req_in.adr == `REG_EVENT_STAT);
  assign event_set_wr = reg_write(wr_access, wb_req_in, `REG_EVENT_SET);
  assign arg_wr       = reg_write(wr_access, wb_req_in, `REG_ARGUMENT);
  assign scan_wr      = reg_write(wr_access, wb_req_in, `REG_SCAN);
  assign relay_wr     = reg_write(wr_access, wb_req_in, `REG_RELAY);

  // Summary bits of the status byte
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[`STB_ESB_BIT] = |(event_stat & event_enable);
    status_byte[`STB_MAV_BIT] = answer_valid;
    status_byte[`STB_RQS_BIT] = |(status_byte & sreq_enable);
  end
  assign srq_out  = status_byte[`STB_RQS_BIT];
  assign busy_out = (state != ST_IDLE);

  // Read multiplexer; unmapped addresses read as zero
  always_comb
  begin
    case (wb_req_in.adr)
      `REG_COMMAND:      rdata = {28'h0, cmd};
      `REG_ARGUMENT:     rdata = {24'h0, arg};
      `REG_ANSWER:       rdata = answer;
      `REG_STATUS:       rdata = {27'h0, err_sync[1], opc_request, answer_valid,
                                  pend_sync[1], busy_out};
      `REG_EVENT_ENABLE: rdata = {24'h0, event_enable};
      `REG_SREQ_ENABLE:  rdata = {24'h0, sreq_enable};
      `REG_STATUS_BYTE:  rdata = {24'h0, status_byte};
      `REG_EVENT_STAT:   rdata = {24'h0, event_stat};
      `REG_RELAY:        rdata = {16'h0, relay_out};
      `REG_SCAN:         rdata = {30'h0, scan_ctl};
      `REG_SELFTEST:     rdata = {16'h0, selftest};
      default:           rdata = 32'h0;
    endcase
  end

  // Ack one cycle after request, dropped the cycle after
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ack        <= 1'b0;
      wb_rsp_out <= '0;
    end
    else
    begin
      ack            <= wb_req_in.cyc && wb_req_in.stb && !ack;
      wb_rsp_out.ack <= wb_req_in.cyc && wb_req_in.stb && !ack;
      wb_rsp_out.dat <= rdata;
    end
  end

  // ----------------------------------------
  // Command and argument capture, plain registers
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cmd      <= 4'h0;
      arg      <= 8'h00;
      scan_ctl <= 2'h0;
    end
    else
    begin
      if (wr_cmd && state == ST_IDLE)
        cmd <= wb_req_in.dat[3:0];
      if (arg_wr)
        arg <= wb_req_in.dat[7:0];
      if (scan_wr)
        scan_ctl <= wb_req_in.dat[1:0];
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
          if (wr_cmd)
            state <= ST_EXEC;
        ST_EXEC:
          if (cmd == `CMD_OPC || cmd == `CMD_OPQ || cmd == `CMD_WAI)
            state <= ST_WAIT;
          else if (cmd == `CMD_TST)
            state <= ST_TEST;
          else
            state <= ST_IDLE;
        ST_WAIT:
          if (!pend_sync[1])
            state <= ST_IDLE;
        ST_TEST:
          if (test_done)
            state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Self-test ends once busy, having been seen, drops, or when the hold runs out;
  // the hold is timed from test start, so the busy pin's sync latency counts in it
  assign test_done = (state == ST_TEST) &&
                     ((busy_seen && !busy_sync[1]) || busy_count >= 24'(BUSY_HOLD));

  // Self-test busy hold counter, busy and interrupt watch
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      busy_count <= 24'h0;
      irq_seen   <= 1'b0;
      busy_seen  <= 1'b0;
    end
    else if (state == ST_TEST)
    begin
      if (busy_count < 24'(BUSY_HOLD))
        busy_count <= busy_count + 24'h1;
      if (irq_sync[1])
        irq_seen <= 1'b1;
      if (busy_sync[1])
        busy_seen <= 1'b1;
    end
    else
    begin
      busy_count <= 24'h0;
      irq_seen   <= 1'b0;
      busy_seen  <= 1'b0;
    end
  end

  // Self-test result code
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      selftest <= `TST_PASS;
    else if (test_done)
    begin
      if (fault_sync[1])
        selftest <= `TST_FIRMWARE;
      else if (fault2_sync[1])
        selftest <= `TST_BUS;
      else if (!irq_seen && !irq_sync[1])
        selftest <= `TST_NO_IRQ;
      else if (!busy_seen || busy_count < 24'(BUSY_HOLD))
        selftest <= `TST_BUSY;
      else
        selftest <= `TST_PASS;
    end
  end

  // ----------------------------------------
  // Output queue, one answer word
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      answer       <= 32'h0;
      answer_valid <= 1'b0;
    end
    else if (state == ST_EXEC)
    begin
      answer_valid <= 1'b1;
      case (cmd)
        `CMD_IDN: answer <= `ID_WORD;
        `CMD_ESQ: answer <= {24'h0, event_enable};
        `CMD_ESR: answer <= {24'h0, event_stat};
        `CMD_SRQ: answer <= {24'h0, sreq_enable};
        `CMD_STB: answer <= {24'h0, status_byte};
        default:  answer_valid <= answer_valid;
      endcase
    end
    else if (state == ST_WAIT && !pend_sync[1] && cmd == `CMD_OPQ)
    begin
      answer       <= 32'h1;
      answer_valid <= 1'b1;
    end
    else if (test_done)
      answer_valid <= 1'b1;
    else if (rd_access && wb_req_in.adr == `REG_ANSWER)
      answer_valid <= 1'b0;
  end

  // ----------------------------------------
  // Event status, enables and request flag
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      event_stat   <= 8'h00;
      event_enable <= 8'h00;
      sreq_enable  <= 8'h00;
      opc_request  <= 1'b0;
    end
    else
    begin
      if (state == ST_EXEC && cmd == `CMD_ESE)
        event_enable <= arg;
      if (state == ST_EXEC && cmd == `CMD_SRE)
        sreq_enable <= arg;
      // Clear first, then sets win over it
      if ((state == ST_EXEC && (cmd == `CMD_CLS || cmd == `CMD_ESR)) || esr_read)
        event_stat <= 8'h00 | (event_set_wr ? wb_req_in.dat[7:0] : 8'h00);
      else if (event_set_wr)
        event_stat <= event_stat | wb_req_in.dat[7:0];
      if (state == ST_EXEC && cmd == `CMD_CLS)
        opc_request <= 1'b0;
      if (state == ST_WAIT && !pend_sync[1] && cmd == `CMD_OPC)
      begin
        opc_request <= 1'b1;
        event_stat[`EVT_OPC_BIT] <= 1'b1;
      end
    end
  end
  assign error_clear_out = (state == ST_EXEC) && (cmd == `CMD_CLS);

  // ----------------------------------------
  // Relays, saved configuration and scan step
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      relay_out   <= `RELAY_RESET;
      saved_relay <= `RELAY_RESET;
    end
    else
    begin
      if (state == ST_EXEC && cmd == `CMD_RST)
        relay_out <= `RELAY_RESET;
      else if (state == ST_EXEC && cmd == `CMD_RCL)
        relay_out <= saved_relay;
      else if (relay_wr && state == ST_IDLE)
        relay_out <= wb_req_in.dat[15:0];
      if (state == ST_EXEC && cmd == `CMD_SAV)
        saved_relay <= relay_out;
    end
  end

  // One-cycle scan advance pulse under bus trigger source
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      scan_step_out <= 1'b0;
    else
      scan_step_out <= (state == ST_EXEC) && (cmd == `CMD_TRG) &&
                       scan_ctl[`SCAN_EN_BIT] && scan_ctl[`SCAN_BUS_BIT];
  end
endmodule : common_command_status_handler

// ### verif/ccmd_props.sv
// Port-level assertions for the common command handler
`timescale 1ns/1ps
`include "ccmd_consts.svh"
module ccmd_props (
  input wire logic                 clk_in,
  input wire logic                 rst_in,
  input wire ccmd_pkg::wb_req_type wb_req_in,
  input wire ccmd_pkg::wb_rsp_type wb_rsp_out,
  input wire logic                 error_clear_out,
  input wire logic [15:0]          relay_out,
  input wire logic                 scan_step_out,
  input wire logic                 srq_out,
  input wire logic                 busy_out
);
  import ccmd_pkg::*;
  logic take, cmd_wr, cls_wr;
  // Request taken, and command writes accepted while idle
  assign take = wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack;
  assign cmd_wr = take && wb_req_in.we && wb_req_in.adr == `REG_COMMAND && wb_req_in.sel[0]
    && !busy_out;
  assign cls_wr = cmd_wr && wb_req_in.dat[3:0] == `CMD_CLS;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_ack_latency: assert property (take |=> wb_rsp_out.ack)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_rsp_out.ack |-> $past(take))
    else $error("ack without a request");
  a_reset_clears: assert property (disable iff (1'b0) rst_in |=> relay_out == 16'h0000
    && !scan_step_out && !busy_out && !srq_out && !wb_rsp_out.ack)
    else $error("outputs not cleared by reset");
  a_cmd_busy: assert property (cmd_wr |=> busy_out)
    else $error("command did not raise busy");
  a_rst_opens: assert property (cmd_wr && wb_req_in.dat[3:0] == `CMD_RST
    |-> ##[1:3] relay_out == `RELAY_RESET)
    else $error("relays not opened by reset command");
  a_clear_cause: assert property (error_clear_out |-> $past(cls_wr))
    else $error("error clear without clear-status");
  a_clear_pulse: assert property (error_clear_out |=> !error_clear_out)
    else $error("error clear longer than one cycle");
  a_step_pulse: assert property (scan_step_out |=> !scan_step_out)
    else $error("scan step longer than one cycle");
  a_step_cause: assert property (scan_step_out |-> $past(busy_out) || $past(busy_out, 2))
    else $error("scan step without a command");
endmodule : ccmd_props
bind common_command_status_handler ccmd_props chk (.clk_in(clk_in), .rst_in(rst_in),
  .wb_req_in(wb_req_in), .wb_rsp_out(wb_rsp_out), .error_clear_out(error_clear_out),
  .relay_out(relay_out), .scan_step_out(scan_step_out), .srq_out(srq_out),
  .busy_out(busy_out));

// ### verif/pin_model.sv
// Model of the matrix module's status pins seen by the handler
`timescale 1ns/1ps
module pin_model (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  input  wire logic clear_in,
  input  wire logic push_in,
  input  wire logic pend_go_in,
  input  wire logic short_in,
  input  wire logic irq_ok_in,
  output logic      pending_out,
  output logic      busy_out,
  output logic      irq_out,
  output logic      err_out
);
  logic [4:0] busy_cnt;
  logic [5:0] pend_cnt;
  logic       run_d;
  // Module busy held at each command start, short when asked
  always_ff @(posedge clk_in)
  begin
    run_d <= run_in;
    if (rst_in)
      busy_cnt <= 5'h00;
    else if (run_in && !run_d)
      busy_cnt <= short_in ? 5'h05 : 5'h1e;
    else if (busy_cnt != 5'h00)
      busy_cnt <= busy_cnt - 5'h01;
  end
  // Pending work lasts a fixed span after each start
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pend_cnt <= 6'h00;
    else if (pend_go_in)
      pend_cnt <= 6'h28;
    else if (pend_cnt != 6'h00)
      pend_cnt <= pend_cnt - 6'h01;
  end
  // Error queue holds an entry until cleared
  always_ff @(posedge clk_in)
  begin
    if (rst_in || clear_in)
      err_out <= 1'b0;
    else if (push_in)
      err_out <= 1'b1;
  end
  // Interrupt pulsed early in the busy span when allowed
  assign irq_out = irq_ok_in && (busy_cnt == 5'h1b || busy_cnt == 5'h04);
  assign busy_out = busy_cnt != 5'h00;
  assign pending_out = pend_cnt != 6'h00;
endmodule : pin_model

// ### verif/tb_top.sv
// Self-checking bench for the common command handler
`timescale 1ns/1ps
`include "ccmd_consts.svh"
module tb_top;
  import ccmd_pkg::*;
  typedef struct packed {logic [7:0] pa; logic [31:0] pd; logic [3:0] c;
    logic [7:0] ra; logic [31:0] ex;} row_type;
  logic       clk_in = 1'b0, rst_in = 1'b1;
  wb_req_type req = '0;
  wb_rsp_type rsp;
  logic       fw = 1'b0, bus = 1'b0, push = 1'b0, pend_go = 1'b0, short_b = 1'b0, irq_ok = 1'b1;
  logic       pend_pin, mbusy, irq_pin, err_pin, err_clr, step, srq, busy;
  logic [15:0] relay;
  logic [31:0] q;
  int         mismatches = 0, n_checks = 0, cycles = 0, steps = 0, n;
  row_type    rows [12] = '{
    '{`REG_RELAY, 32'ha5c3, `CMD_SAV, `REG_RELAY, 32'ha5c3},
    '{`REG_RELAY, 32'h0f0f, `CMD_RCL, `REG_RELAY, 32'ha5c3},
    '{`REG_ARGUMENT, 32'h0, `CMD_RST, `REG_RELAY, 32'h0},
    '{`REG_ARGUMENT, 32'h0, `CMD_IDN, `REG_ANSWER, `ID_WORD},
    '{`REG_ARGUMENT, 32'h3c, `CMD_ESE, `REG_EVENT_ENABLE, 32'h3c},
    '{`REG_ARGUMENT, 32'h0, `CMD_ESQ, `REG_ANSWER, 32'h3c},
    '{`REG_ARGUMENT, 32'h20, `CMD_SRE, `REG_SREQ_ENABLE, 32'h20},
    '{`REG_ARGUMENT, 32'h0, `CMD_SRQ, `REG_ANSWER, 32'h20},
    '{`REG_ARGUMENT, 32'h0, `CMD_OPC, `REG_STATUS, 32'h08},
    '{`REG_ARGUMENT, 32'h0, `CMD_ESR, `REG_ANSWER, 32'h01},
    '{`REG_ARGUMENT, 32'h0, `CMD_ESR, `REG_ANSWER, 32'h00},
    '{`REG_ARGUMENT, 32'h0, `CMD_STB, `REG_ANSWER, 32'h00}};
  logic [3:0] tcfg [5] = '{4'b0010, 4'b1101, 4'b0110, 4'b0000, 4'b0011};
  logic [15:0] tcode [5] = '{`TST_PASS, `TST_FIRMWARE, `TST_BUS, `TST_NO_IRQ, `TST_BUSY};
  // Clock at 25 MHz
  always #20 clk_in = ~clk_in;
  common_command_status_handler #(.BUSY_HOLD(20)) uut (.clk_in(clk_in), .rst_in(rst_in),
    .wb_req_in(req), .wb_rsp_out(rsp), .pending_in(pend_pin), .fw_fault_in(fw),
    .bus_fault_in(bus), .module_irq_in(irq_pin), .module_busy_in(mbusy),
    .error_nonempty_in(err_pin), .error_clear_out(err_clr), .relay_out(relay),
    .scan_step_out(step), .srq_out(srq), .busy_out(busy));
  pin_model pins (.clk_in(clk_in), .rst_in(rst_in), .run_in(busy), .clear_in(err_clr),
    .push_in(push), .pend_go_in(pend_go), .short_in(short_b), .irq_ok_in(irq_ok),
    .pending_out(pend_pin), .busy_out(mbusy), .irq_out(irq_pin), .err_out(err_pin));
  // Step counter and hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (step === 1'b1)
      steps++;
    if (cycles == 6000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      mismatches++;
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do @(posedge clk_in); while (rsp.ack !== 1'b1);
    q = rsp.dat;
    req <= '0;
  endtask : wb
  task automatic cmd(input logic [3:0] c);
    wb(1'b1, `REG_COMMAND, {28'h0, c});
  endtask : cmd
  task automatic idle;
    do wb(1'b0, `REG_STATUS, 32'h0); while (q[0] !== 1'b0);
  endtask : idle
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    check({15'h0, busy, relay}, 32'h0);
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].pa, rows[i].pd);
      cmd(rows[i].c);
      idle();
      wb(1'b0, rows[i].ra, 32'h0);
      check(q, rows[i].ex);
      $display("row %0d done", i);
    end
    wb(1'b1, `REG_EVENT_SET, 32'h04);
    push <= 1'b1;
    @(posedge clk_in);
    push <= 1'b0;
    wb(1'b0, `REG_STATUS_BYTE, 32'h0);
    check(q, 32'h60);
    check({31'h0, srq}, 32'h1);
    wb(1'b0, `REG_STATUS, 32'h0);
    check(q, 32'h18);
    cmd(`CMD_CLS);
    idle();
    wb(1'b0, `REG_STATUS, 32'h0);
    check(q, 32'h0);
    wb(1'b0, `REG_EVENT_STAT, 32'h0);
    check({q[31:1], srq}, 32'h0);
    $display("clear test done");
    for (int k = 0; k < 2; k++)
    begin
      pend_go <= 1'b1;
      @(posedge clk_in);
      pend_go <= 1'b0;
      repeat (3) @(posedge clk_in);
      cmd(k ? `CMD_WAI : `CMD_OPQ);
      wb(1'b0, `REG_STATUS, 32'h0);
      check({30'h0, q[2], q[0]}, 32'h1);
      wb(1'b1, `REG_ARGUMENT, 32'h11);
      cmd(`CMD_ESE);
      idle();
      wb(1'b0, k ? `REG_EVENT_ENABLE : `REG_ANSWER, 32'h0);
      check(q, k ? 32'h3c : 32'h1);
      $display("pending test %0d done", k);
    end
    for (int v = 0; v < 4; v++)
    begin
      wb(1'b1, `REG_SCAN, 32'(v));
      n = steps;
      cmd(`CMD_TRG);
      idle();
      check(32'(steps - n), 32'(v == 3));
    end
    $display("trigger test done");
    for (int i = 0; i < 5; i++)
    begin
      {fw, bus, irq_ok, short_b} <= tcfg[i];
      cmd(`CMD_TST);
      idle();
      wb(1'b0, `REG_SELFTEST, 32'h0);
      check(q, {16'h0, tcode[i]});
      $display("self-test %0d done", i);
    end
    // Reset in mid-run clears relays and enables
    wb(1'b1, `REG_RELAY, 32'h1234);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    check({15'h0, busy, relay}, 32'h0);
    wb(1'b0, `REG_EVENT_ENABLE, 32'h0);
    check(q, 32'h0);
    $display("mid reset test done");
    give_verdict();
  end
endmodule : tb_top
